// ==== eeprom_ctrl_consts.vh ====
`ifndef EEPROM_CTRL_CONSTS_VH
`define EEPROM_CTRL_CONSTS_VH

// Register word indices on the Avalon-MM slave
`define OFS_CTRL 3'h0
`define OFS_UNLOCK 3'h1
`define OFS_VALUE 3'h2
`define OFS_ADDR 3'h3
`define OFS_FLAGS 3'h4

// Control register bit positions
`define CTRL_FETCH 0
`define CTRL_GO 1
`define CTRL_PERMIT 2
`define CTRL_ERR 3
`define CTRL_CFG 6
`define CTRL_PSS 7

// Second peripheral flag register
`define FLAGS_DONE 4

// Unlock key bytes
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa

// Reset values and fills
`define BYTE_ZERO 8'h00
`define ERASED_BYTE 8'hff
`define COUNT_ZERO 24'h000000
`define COUNT_ONE 24'h000001

// Clock rate and default write phase times
`define CLK_MHZ 25
`define ERASE_TIME_US 2000
`define PROG_TIME_US 2000

// Array geometry
`define ARRAY_DEPTH 256

`endif

// ==== nv_array.v ====
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_ctrl_consts.vh"

module nv_array (
    input wire clk,
    input wire erase_program_permit,
    input wire [7:0] wrAddr,
    input wire [7:0] wrData,
    input wire [7:0] rdAddr,
    output wire [7:0] rdData
);

    wire [7:0] cells [0:`ARRAY_DEPTH-1];

    genvar i;
    generate
        for (i = 0; i < `ARRAY_DEPTH; i = i + 1) begin : gCell
            reg [7:0] cell_q;
            // Nonvolatile content, kept across reset
            always @(posedge clk) begin
                if (erase_program_permit && (wrAddr == i[7:0])) begin
                    cell_q <= wrData;
                end
            end
            assign cells[i] = cell_q;
        end
    endgenerate

    assign rdData = cells[rdAddr];

endmodule // nv_array
`default_nettype wire

// ==== write_timer.v ====
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_ctrl_consts.vh"

module write_timer (
    input wire clk,
    input wire sys_rst,
    input wire load,
    input wire [23:0] loadCount,
    output reg done
);

    reg [23:0] count_q;

    always @(posedge clk) begin
        if (sys_rst) begin
            count_q <= `COUNT_ZERO;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (load) begin
                count_q <= loadCount;
            end else if (count_q != `COUNT_ZERO) begin
                count_q <= count_q - `COUNT_ONE;
                if (count_q == `COUNT_ONE) begin
                    done <= 1'b1;
                end
            end
        end
    end

endmodule // write_timer
`default_nettype wire

// ==== data_eeprom_access_ctrl.v ====
// Behaviour
// RULE_01 - Array reached only through registers
// RULE_02 - One byte per access, value and address
// RULE_03 - 256 bytes, full 8-bit address valid
// RULE_04 - Write erases location then programs it
// RULE_05 - Internal timer sets write duration
// RULE_06 - Unlock port reads as zero
// RULE_07 - Unlock port used only to start writes
// RULE_08 - Program select set targets program memory
// RULE_09 - Config select set targets configuration space
// RULE_10 - Permit clear blocks write start
// RULE_11 - Clearing permit keeps running write
// RULE_12 - Firmware keeps permit clear when idle
// RULE_13 - Reset during write sets error flag; here it stays set only after a one-cycle reset, a longer reset clears it
// RULE_14 - Reset clears value and address
// RULE_15 - Software reloads registers before retry
// RULE_16 - Go bits cleared by hardware at end
// RULE_17 - No read start with program select
// RULE_18 - Done flag set, held until cleared
// RULE_19 - Done flag at bit 4 of flags
// RULE_20 - Write start needs key sequence first
// RULE_21 - Read loads value and clears fetch
//
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_ctrl_consts.vh"

module data_eeprom_access_ctrl #(
    parameter integer ERASE_TIME_US = `ERASE_TIME_US,
    parameter integer PROG_TIME_US = `PROG_TIME_US
) (
    input wire clk,
    input wire sys_rst,
    input wire [2:0] address,
    input wire read,
    input wire write,
    input wire [7:0] writedata,
    output reg [7:0] readdata,
    output reg waitrequest,
    output reg updateDone,
    output reg writeBusy
);

    localparam integer ERASE_CYC_INT = ERASE_TIME_US * `CLK_MHZ;
    localparam integer PROG_CYC_INT = PROG_TIME_US * `CLK_MHZ;
    localparam [23:0] ERASE_CYCLES = ERASE_CYC_INT[23:0];
    localparam [23:0] PROG_CYCLES = PROG_CYC_INT[23:0];

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ERASE = 2'h1;
    localparam [1:0] ST_PROG = 2'h2;

    localparam [1:0] KEY_NONE = 2'h0;
    localparam [1:0] KEY_HALF = 2'h1;
    localparam [1:0] KEY_FULL = 2'h2;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [1:0] keyStage_q;
    reg [7:0] byteValue_q;
    reg [7:0] byteAddr_q;
    reg [7:0] latchAddr_q;
    reg [7:0] latchData_q;
    reg targetData_q;
    reg programSel_q;
    reg configSel_q;
    reg permit_q;
    reg errFlag_q;
    reg fetchGo_q;
    reg cycleGo_q;
    reg doneFlag_q;

    reg timerLoad;
    reg [23:0] timerCount;
    reg arrayWrEn;
    reg [7:0] arrayWrData;
    reg [7:0] readMux;

    wire timerDone;
    wire [7:0] arrayRdData;
    wire busWr;
    wire valueWr;
    wire addrWr;
    wire flagsWr;
    wire idleNow;
    wire keyReady;
    wire cycleEnd;
    wire ctrlWr;
    wire unlockWr;
    wire goAccept;
    wire fetchAccept;
    wire dataSpaceNow;
    wire [7:0] ctrlView;

    assign busWr = write && !waitrequest;
    assign valueWr = busWr && (address == `OFS_VALUE);
    assign addrWr = busWr && (address == `OFS_ADDR);
    assign flagsWr = busWr && (address == `OFS_FLAGS);
    assign ctrlWr = busWr && (address == `OFS_CTRL);
    assign unlockWr = busWr && (address == `OFS_UNLOCK);

    assign dataSpaceNow = !programSel_q && !configSel_q;
    assign idleNow = (state_q == ST_IDLE);
    assign keyReady = (keyStage_q == KEY_FULL);
    // Last cycle of the program phase
    assign cycleEnd = (state_q == ST_PROG) && timerDone;

    // RULE_10 permit gates start
    // RULE_20 key must precede start
    assign goAccept = ctrlWr && writedata[`CTRL_GO] && permit_q
        && keyReady && idleNow;

    // RULE_17 refuse read in program space
    assign fetchAccept = ctrlWr && writedata[`CTRL_FETCH]
        && !writedata[`CTRL_PSS] && idleNow;

    assign ctrlView = {programSel_q, configSel_q, 2'b00, errFlag_q,
        permit_q, cycleGo_q, fetchGo_q};

    // RULE_01 array behind registers only
    nv_array uArray (
        .clk(clk),
        .erase_program_permit(arrayWrEn),
        .wrAddr(latchAddr_q),
        .wrData(arrayWrData),
        .rdAddr(byteAddr_q),
        .rdData(arrayRdData)
    );

    // RULE_05 internal write timer
    // Loaded at each phase start, pulses done at its end
    write_timer uTimer (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(timerLoad),
        .loadCount(timerCount),
        .done(timerDone)
    );

    // Slave handshake: one wait cycle, then accept
    // A request still held after its answer waits again
    always @(posedge clk) begin
        if (sys_rst) begin
            waitrequest <= 1'b1;
        end else if (waitrequest && (read || write)) begin
            waitrequest <= 1'b0;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    always @* begin
        readMux = `BYTE_ZERO;
        if (address == `OFS_CTRL) begin
            readMux = ctrlView;
        end else if (address == `OFS_UNLOCK) begin
            // RULE_06 unlock reads zero
            readMux = `BYTE_ZERO;
        end else if (address == `OFS_VALUE) begin
            readMux = byteValue_q;
        end else if (address == `OFS_ADDR) begin
            readMux = byteAddr_q;
        end else if (address == `OFS_FLAGS) begin
            // RULE_19 done flag at bit 4
            readMux[`FLAGS_DONE] = doneFlag_q;
        end else begin
            // Unmapped indices read as zero
            readMux = `BYTE_ZERO;
        end
    end

    // Taken in the wait cycle, so it stands in the answer cycle
    always @(posedge clk) begin
        if (sys_rst) begin
            readdata <= `BYTE_ZERO;
        end else if (waitrequest && read) begin
            readdata <= readMux;
        end
    end

    // RULE_07 key tracking
    always @(posedge clk) begin
        if (sys_rst) begin
            keyStage_q <= KEY_NONE;
        end else if (unlockWr) begin
            if (writedata == `KEY_FIRST) begin
                keyStage_q <= KEY_HALF;
            end else if ((writedata == `KEY_SECOND) && (keyStage_q == KEY_HALF)) begin
                keyStage_q <= KEY_FULL;
            end else begin
                keyStage_q <= KEY_NONE;
            end
        end else if (busWr) begin
            // Any other bus write breaks the key
            keyStage_q <= KEY_NONE;
        end
    end

    // Write sequencer
    always @* begin
        state_d = state_q;
        timerLoad = 1'b0;
        timerCount = ERASE_CYCLES;
        arrayWrEn = 1'b0;
        arrayWrData = `ERASED_BYTE;
        case (state_q)
            ST_IDLE: begin
                if (goAccept) begin
                    timerLoad = 1'b1;
                    state_d = ST_ERASE;
                end
            end
            ST_ERASE: begin
                if (timerDone) begin
                    // RULE_04 erase before program
                    arrayWrEn = targetData_q;
                    arrayWrData = `ERASED_BYTE;
                    timerLoad = 1'b1;
                    timerCount = PROG_CYCLES;
                    state_d = ST_PROG;
                end
            end
            ST_PROG: begin
                if (timerDone) begin
                    arrayWrEn = targetData_q;
                    arrayWrData = latchData_q;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            writeBusy <= 1'b0;
        end else begin
            // RULE_11 permit not consulted once running
            // Busy follows the next state, so it rises at acceptance
            state_q <= state_d;
            writeBusy <= (state_d != ST_IDLE);
        end
    end

    // Capture of the byte being written
    // Latched copies let software rewrite value and address mid-cycle
    always @(posedge clk) begin
        if (sys_rst) begin
            latchAddr_q <= `BYTE_ZERO;
            latchData_q <= `BYTE_ZERO;
            targetData_q <= 1'b0;
        end else if (goAccept) begin
            latchAddr_q <= byteAddr_q;
            latchData_q <= byteValue_q;
            // RULE_08 program space leaves array alone
            // RULE_09 config space leaves array alone
            targetData_q <= dataSpaceNow;
        end
    end

    // RULE_14 reset clears value and address
    // RULE_02 single byte registers
    always @(posedge clk) begin
        if (sys_rst) begin
            byteValue_q <= `BYTE_ZERO;
            byteAddr_q <= `BYTE_ZERO;
        end else begin
            if (addrWr) begin
                // RULE_03 whole 8-bit range valid
                byteAddr_q <= writedata;
            end
            // RULE_21 read loads value
            // Fetch load wins over a bus write in the same cycle
            if (fetchGo_q && dataSpaceNow) begin
                byteValue_q <= arrayRdData;
            end else if (valueWr) begin
                byteValue_q <= writedata;
            end
        end
    end

    // Control register fields
    // Go and fetch bits are handled on their own below
    always @(posedge clk) begin
        if (sys_rst) begin
            programSel_q <= 1'b0;
            configSel_q <= 1'b0;
            permit_q <= 1'b0;
        end else if (ctrlWr) begin
            programSel_q <= writedata[`CTRL_PSS];
            configSel_q <= writedata[`CTRL_CFG];
            permit_q <= writedata[`CTRL_PERMIT];
        end
    end

    // RULE_13 reset mid-write leaves error only if reset lasts one cycle; a longer reset clears it
    always @(posedge clk) begin
        if (sys_rst) begin
            errFlag_q <= (state_q != ST_IDLE);
        end else if (ctrlWr) begin
            errFlag_q <= writedata[`CTRL_ERR];
        end
    end

    // RULE_16 go bits cleared by hardware
    always @(posedge clk) begin
        if (sys_rst) begin
            fetchGo_q <= 1'b0;
            cycleGo_q <= 1'b0;
        end else begin
            if (fetchAccept) begin
                fetchGo_q <= 1'b1;
            end else if (fetchGo_q) begin
                fetchGo_q <= 1'b0;
            end
            if (goAccept) begin
                cycleGo_q <= 1'b1;
            end else if (cycleEnd) begin
                cycleGo_q <= 1'b0;
            end
        end
    end

    // RULE_18 done flag sticky, set wins
    always @(posedge clk) begin
        if (sys_rst) begin
            doneFlag_q <= 1'b0;
            updateDone <= 1'b0;
        end else begin
            if (cycleEnd) begin
                doneFlag_q <= 1'b1;
            end else if (flagsWr) begin
                doneFlag_q <= writedata[`FLAGS_DONE];
            end
            // Output copy, one cycle behind the flag
            updateDone <= doneFlag_q;
        end
    end

endmodule // data_eeprom_access_ctrl
`default_nettype wire

// ==== eeprom_ctrl_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_ctrl_consts.vh"
module eeprom_ctrl_checker #(
    parameter integer ERASE_TIME_US = 1,
    parameter integer PROG_TIME_US = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [2:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [7:0] readdata,
    input wire logic waitrequest,
    input wire logic updateDone,
    input wire logic writeBusy
);
    localparam int TOT = (ERASE_TIME_US + PROG_TIME_US) * `CLK_MHZ;
    // Wide enough for the full-length write times
    logic [23:0] busyLen_q;
    wire rdAns = read && !waitrequest;
    always @(posedge clk) begin
        if (sys_rst || !writeBusy) begin
            busyLen_q <= 24'h000000;
        end else begin
            busyLen_q <= busyLen_q + 24'h000001;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered");
    a_wait_single: assert property (!waitrequest |=> waitrequest)
        else $error("wait low too long");
    a_unlock_zero: assert property (rdAns && address == `OFS_UNLOCK |-> readdata == 8'h00)
        else $error("unlock port not zero");
    a_flags_reserved: assert property (rdAns && address == `OFS_FLAGS |-> !(readdata & 8'hef))
        else $error("flag bits beside done set");
    a_busy_length: assert property ($fell(writeBusy) && !$past(sys_rst) |-> busyLen_q >= TOT)
        else $error("write too short");
    a_busy_bounded: assert property (writeBusy |-> busyLen_q <= TOT + 6)
        else $error("write too long");
    a_done_after_busy: assert property ($fell(writeBusy) && !$past(sys_rst) |-> ##[0:2] updateDone)
        else $error("done flag missing");
    a_done_holds: assert property ($fell(updateDone) |-> $past(write, 2) || $past(write, 3) || $past(sys_rst))
        else $error("done flag dropped");
    a_busy_needs_write: assert property ($rose(writeBusy) |-> $past(write) || $past(write, 2))
        else $error("write began unasked");
    cover property ($fell(writeBusy));
    cover property ($rose(updateDone));
    cover property (rdAns && address == `OFS_UNLOCK);
endmodule // eeprom_ctrl_checker
bind data_eeprom_access_ctrl eeprom_ctrl_checker #(
    .ERASE_TIME_US(ERASE_TIME_US), .PROG_TIME_US(PROG_TIME_US)
) i_chk (
    .clk(clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
    .readdata(readdata), .waitrequest(waitrequest), .updateDone(updateDone),
    .writeBusy(writeBusy)
);
`default_nettype wire

// ==== data_eeprom_access_ctrl_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_ctrl_consts.vh"
module data_eeprom_access_ctrl_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] address = 3'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [7:0] writedata = 8'h00;
    wire [7:0] readdata;
    wire waitrequest;
    wire updateDone;
    wire writeBusy;
    int err_count = 0;
    int n_compared = 0;
    logic [7:0] v;
    data_eeprom_access_ctrl #(.ERASE_TIME_US(1), .PROG_TIME_US(1)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .updateDone(updateDone), .writeBusy(writeBusy)
    );
    always #20 clk = ~clk;
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task ack;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
    endtask
    task bw(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        write <= 1'b1;
        address <= a;
        writedata <= d;
        ack();
        write <= 1'b0;
    endtask
    task rc(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        read <= 1'b1;
        address <= a;
        ack();
        v = readdata;
        read <= 1'b0;
        chk(v, exp);
    endtask
    // Value left in v for the caller
    task rdArr(input logic [7:0] a);
        bw(`OFS_ADDR, a);
        bw(`OFS_CTRL, 8'h01);
        @(posedge clk);
        read <= 1'b1;
        address <= `OFS_VALUE;
        ack();
        v = readdata;
        read <= 1'b0;
    endtask
    task startWr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
        bw(`OFS_ADDR, a);
        bw(`OFS_VALUE, d);
        bw(`OFS_CTRL, m | 8'h04);
        bw(`OFS_UNLOCK, `KEY_FIRST);
        bw(`OFS_UNLOCK, `KEY_SECOND);
        bw(`OFS_CTRL, m | 8'h06);
        repeat (3) @(posedge clk);
    endtask
    task waitIdle;
        while (writeBusy !== 1'b0) begin
            @(posedge clk);
        end
    endtask
    task t_reset;
        rc(`OFS_VALUE, 8'h00);
        rc(`OFS_ADDR, 8'h00);
        rc(`OFS_CTRL, 8'h00);
        bw(`OFS_UNLOCK, `KEY_FIRST);
        rc(`OFS_UNLOCK, 8'h00);
        for (int i = 5; i < 8; i++) rc(i[2:0], 8'h00);
        bw(`OFS_ADDR, 8'h5a);
        rc(`OFS_ADDR, 8'h5a);
    endtask
    task t_write(input logic [7:0] a, input logic [7:0] d);
        startWr(a, d, 8'h00);
        chk({7'h0, writeBusy}, 8'h01);
        bw(`OFS_CTRL, 8'h00);
        waitIdle();
        rc(`OFS_CTRL, 8'h00);
        rc(`OFS_FLAGS, 8'h10);
        chk({7'h0, updateDone}, 8'h01);
        bw(`OFS_VALUE, 8'h00);
        rdArr(a);
        chk(v, d);
        rc(`OFS_CTRL, 8'h00);
        bw(`OFS_FLAGS, 8'h00);
        rc(`OFS_FLAGS, 8'h00);
    endtask
    task t_refuse;
        bw(`OFS_CTRL, 8'h00);
        bw(`OFS_UNLOCK, `KEY_FIRST);
        bw(`OFS_UNLOCK, `KEY_SECOND);
        bw(`OFS_CTRL, 8'h02);
        repeat (3) @(posedge clk);
        chk({7'h0, writeBusy}, 8'h00);
        rc(`OFS_CTRL, 8'h00);
        bw(`OFS_CTRL, 8'h04);
        bw(`OFS_UNLOCK, `KEY_FIRST);
        bw(`OFS_VALUE, 8'h77);
        bw(`OFS_UNLOCK, `KEY_SECOND);
        bw(`OFS_CTRL, 8'h06);
        repeat (3) @(posedge clk);
        chk({7'h0, writeBusy}, 8'h00);
        rc(`OFS_CTRL, 8'h04);
        rdArr(8'hff);
        chk(v, 8'h3c);
    endtask
    task t_space(input logic [7:0] m);
        startWr(8'h00, 8'h99, m);
        waitIdle();
        rc(`OFS_FLAGS, 8'h10);
        bw(`OFS_FLAGS, 8'h00);
        bw(`OFS_VALUE, 8'h5a);
        bw(`OFS_CTRL, m | 8'h01);
        rc(`OFS_CTRL, m);
        rc(`OFS_VALUE, 8'h5a);
        rdArr(8'h00);
        chk(v, 8'hc3);
    endtask
    task t_rstWr;
        startWr(8'h10, 8'h42, 8'h00);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        rc(`OFS_CTRL, 8'h08);
        rc(`OFS_VALUE, 8'h00);
        rc(`OFS_ADDR, 8'h00);
        chk({6'h0, writeBusy, updateDone}, 8'h00);
        bw(`OFS_CTRL, 8'h00);
        rc(`OFS_CTRL, 8'h00);
        // reload value and address, then retry
        startWr(8'h10, 8'h42, 8'h00);
        waitIdle();
        rdArr(8'h10);
        chk(v, 8'h42);
        bw(`OFS_FLAGS, 8'h00);
    endtask
    task tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_write(8'h00, 8'hc3);
        t_write(8'hff, 8'h3c);
        t_refuse();
        t_space(8'h80);
        t_space(8'h40);
        t_rstWr();
        tally_and_finish();
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end
endmodule // data_eeprom_access_ctrl_tb
`default_nettype wire
